// [rtl/pmx_regs.svh]
`ifndef PMX_REGS_SVH
`define PMX_REGS_SVH

// register byte offsets
`define PMX_OFS_IO_EN   5'h00
`define PMX_OFS_DIR     5'h04
`define PMX_OFS_PULLDN  5'h08
`define PMX_OFS_DOUT    5'h0C
`define PMX_OFS_PIN     5'h10
`define PMX_OFS_CTRL    5'h14
`define PMX_OFS_PBASE   5'h18
`define PMX_OFS_STAT    5'h1C

// control and status register fields
`define PMX_CTRL_EXT    0
`define PMX_CTRL_DA     1
`define PMX_CTRL_SPACE  2
`define PMX_STAT_STRAP  0
`define PMX_STAT_DONE   1

// power-on defaults per channel
`define PMX_RST_IO_EN   32'hFFFF_FC0F
`define PMX_RST_PULLDN  32'h00C0_0402
`define PMX_RST_DIR     32'h0000_0000
`define PMX_RST_DOUT    32'hFFFF_FFFF
`define PMX_STRAP_CH    32'h2400_0000

// pull options forced in I/O mode
`define PMX_FORCE_UP    32'h0000_03B0
`define PMX_FORCE_DN    32'h0000_0040

// peripheral region indices
`define PMX_REGION7     3'h6
`define PMX_REGION6     3'h5

// strap sampling point after reset release
`define PMX_STRAP_DLY   2'h3

`endif

// [rtl/pmx_pkg.sv]
package pmx_pkg;

  // processor bus side seen by the mux
  typedef struct packed {
    logic [19:0] addr;
    logic        ale;
    logic        cycle;
    logic        is_io;
    logic        ul_cycle;
    logic        hold;
  } pmx_cpu_t;

  typedef struct packed {
    logic [31:0] s1;
    logic [31:0] s2;
    logic [31:0] s3;
    logic [31:0] pin;
    logic [31:0] io_en;
    logic [31:0] dir;
    logic [31:0] pulldn;
    logic [31:0] dout;
    logic        ext;
    logic        da;
    logic        space;
    logic [8:0]  pbase;
    logic [2:0]  st;
    logic        strap_low;
    logic        done;
    logic [1:0]  cnt;
    logic [19:0] la;
    logic        lio;
    logic        wr;
    logic [31:0] rdata;
    logic [31:0] pad_out;
    logic [31:0] pad_oe_n;
    logic [31:0] pu;
    logic [31:0] pd;
    logic        ad_en;
    logic        strap_pu;
    logic        sel7_n;
  } pmx_state_t;

endpackage

// [rtl/pmx_top.sv]
// Chosen here: register access over Avalon-MM and the register offsets.
`include "pmx_regs.svh"
// Summary of operation
// - 32 shared channels, each with own I/O enable and direction; own pull choice on all but channels 4 to 9.
// - pads are sampled through three stages; in I/O mode outputs drive open-drain only.
// - channels 7, 8 and 9 stay in normal function after power-on reset.
// - channels 4, 5 and 6 stay in normal function after power-on reset.
// - channels 1, 10, 22, 23 reset to pull-down inputs; others except normal channels 4 to 9 to pull-up inputs.
// - channels 4, 5, 7, 8, 9 in I/O mode use pull-up.
// - channel 6 in I/O mode uses pull-down.
// - strap low at reset returns channels 26 and 29 to normal function.
// - strap is sampled a fixed short delay after reset release.
// - strap high: address phase on muxed bus follows the disable bit in ul_cycle cycles, else stays on.
// - strap low: muxed bus always carries address and data.
// - strap pin has weak pull-up, released during hold and float test mode.
// - ext bit 0: channel 2 pin outputs latched address bit 2, held in hold.
// - region-7 select goes low for its 256-byte region; high in hold or reset.
// - peripheral selects assert with the muxed address phase.
// - ext bit 0: channel 3 pin outputs latched address bit 1, held in hold.
module pmx_top (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // avalon-mm slave
  input  wire logic [4:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  // shared pads
  input  wire logic [31:0]       pad_in,
  output logic [31:0]            pad_out,
  output logic [31:0]            pad_oe_n,
  output logic [31:0]            pull_up_en,
  output logic [31:0]            pull_dn_en,
  // normal functions of the pads
  input  wire logic [31:0]       func_out,
  input  wire logic [31:0]       func_oe_n,
  output logic [31:0]            func_in,
  // processor bus and modes
  input  wire pmx_pkg::pmx_cpu_t cpu,
  input  wire logic              all_pins_float_test_mode,
  // strap pin and bus control
  input  wire logic              addr_bus_enable_strap,
  output logic                   strap_pull_en,
  output logic                   addr_ad_enable,
  output logic                   periph_region7_select_n
);

  pmx_pkg::pmx_state_t q_q;
  pmx_pkg::pmx_state_t q_d;

  logic [31:0] wmask;
  logic [31:0] fo;
  logic [31:0] foe;
  logic [31:0] pdsel;
  logic        hit7;
  logic        hit6;
  logic        sel6_n;
  logic        rd_req;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  function automatic pmx_pkg::pmx_state_t rst_state();
    pmx_pkg::pmx_state_t r;
    r          = '0;
    r.io_en    = `PMX_RST_IO_EN;
    r.pulldn   = `PMX_RST_PULLDN;
    r.dir      = `PMX_RST_DIR;
    r.dout     = `PMX_RST_DOUT;
    r.wr       = 1'b1;
    r.pad_oe_n = 32'hFFFF_FFFF;
    r.ad_en    = 1'b1;
    r.strap_pu = 1'b1;
    r.sel7_n   = 1'b1;
    rst_state  = r;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_be
      assign wmask[gi*8 +: 8] = {8{avs_byteenable[gi]}};
    end
  endgenerate

  always_comb begin
    q_d    = q_q;
    rd_req = avs_read & ~avs_write;

    // three stage capture of async pads
    q_d.s1 = pad_in;
    q_d.s2 = q_q.s1;
    q_d.s3 = q_q.s2;
    // a change counts only when stages two and three agree
    q_d.pin = (q_q.pin & (q_q.s2 ^ q_q.s3)) | (q_q.s3 & ~(q_q.s2 ^ q_q.s3));
    q_d.st = {q_q.st[1:0], addr_bus_enable_strap};

    // address latch holds through bus hold
    if (cpu.ale && !cpu.hold) begin
      q_d.la  = cpu.addr;
      q_d.lio = cpu.is_io;
    end

    // selects only qualify during the muxed address phase onward
    hit7 = cpu.cycle && !cpu.hold && !cpu.ale &&
           q_q.la[19:11] == q_q.pbase &&
           q_q.la[10:8] == `PMX_REGION7 && q_q.lio == q_q.space;
    hit6 = cpu.cycle && !cpu.hold && !cpu.ale &&
           q_q.la[19:11] == q_q.pbase &&
           q_q.la[10:8] == `PMX_REGION6 && q_q.lio == q_q.space;
    q_d.sel7_n = ~hit7;
    sel6_n     = ~hit6;

    // normal functions of channels 2 and 3 are built here
    fo     = func_out;
    foe    = func_oe_n;
    fo[2]  = q_q.ext ? ~hit7 : q_q.la[2];
    fo[3]  = q_q.ext ? sel6_n : q_q.la[1];
    foe[2] = 1'b0;
    foe[3] = 1'b0;

    // I/O mode cuts the peripheral off the pad
    q_d.pad_out  = ~q_q.io_en & fo;
    q_d.pad_oe_n = (q_q.io_en & ~(q_q.dir & ~q_q.dout)) |
                   (~q_q.io_en & foe);
    pdsel        = (q_q.pulldn | `PMX_FORCE_DN) & ~`PMX_FORCE_UP;
    q_d.pu       = q_q.io_en & ~pdsel;
    q_d.pd       = q_q.io_en & pdsel;
    q_d.strap_pu = ~(cpu.hold | all_pins_float_test_mode);

    // float test mode releases every pad and pull
    if (all_pins_float_test_mode) begin
      q_d.pad_oe_n = 32'hFFFF_FFFF;
      q_d.pu       = 32'h0000_0000;
      q_d.pd       = 32'h0000_0000;
    end

    // strap low forces address and data on every cycle
    q_d.ad_en = q_q.strap_low | ~(cpu.ul_cycle & q_q.da);

    // one wait cycle per access; answer taken where waitrequest is low
    q_d.wr = 1'b1;
    if ((avs_read || avs_write) && q_q.wr) begin
      q_d.wr = 1'b0;
      if (rd_req) begin
        if (avs_address == `PMX_OFS_IO_EN) begin
          q_d.rdata = q_q.io_en;
        end else if (avs_address == `PMX_OFS_DIR) begin
          q_d.rdata = q_q.dir;
        end else if (avs_address == `PMX_OFS_PULLDN) begin
          q_d.rdata = q_q.pulldn;
        end else if (avs_address == `PMX_OFS_DOUT) begin
          q_d.rdata = q_q.dout;
        end else if (avs_address == `PMX_OFS_PIN) begin
          q_d.rdata = q_q.pin;
        end else if (avs_address == `PMX_OFS_CTRL) begin
          q_d.rdata = {29'h0000_0000, q_q.space, q_q.da, q_q.ext};
        end else if (avs_address == `PMX_OFS_PBASE) begin
          q_d.rdata = {23'h00_0000, q_q.pbase};
        end else if (avs_address == `PMX_OFS_STAT) begin
          q_d.rdata = {30'h0000_0000, q_q.done, q_q.strap_low};
        end else begin
          q_d.rdata = 32'h0000_0000;
        end
      end
    end

    // writes land on the edge that sees waitrequest low
    if (avs_write && !avs_read && !q_q.wr) begin
      if (avs_address == `PMX_OFS_IO_EN) begin
        q_d.io_en = merge(q_q.io_en, avs_writedata, wmask);
      end else if (avs_address == `PMX_OFS_DIR) begin
        q_d.dir = merge(q_q.dir, avs_writedata, wmask);
      end else if (avs_address == `PMX_OFS_PULLDN) begin
        q_d.pulldn = merge(q_q.pulldn, avs_writedata, wmask);
      end else if (avs_address == `PMX_OFS_DOUT) begin
        q_d.dout = merge(q_q.dout, avs_writedata, wmask);
      end else if (avs_address == `PMX_OFS_CTRL) begin
        if (avs_byteenable[0]) begin
          q_d.ext   = avs_writedata[`PMX_CTRL_EXT];
          q_d.da    = avs_writedata[`PMX_CTRL_DA];
          q_d.space = avs_writedata[`PMX_CTRL_SPACE];
        end
      end else if (avs_address == `PMX_OFS_PBASE) begin
        if (avs_byteenable[0]) begin
          q_d.pbase[7:0] = avs_writedata[7:0];
        end
        if (avs_byteenable[1]) begin
          q_d.pbase[8] = avs_writedata[8];
        end
      end
    end

    // strap after the writes so a same-cycle write cannot undo the revert
    if (!q_q.done) begin
      q_d.cnt = q_q.cnt + 2'h1;
      if (q_q.cnt == `PMX_STRAP_DLY) begin
        q_d.done      = 1'b1;
        q_d.strap_low = ~q_q.st[2];
        if (!q_q.st[2]) begin
          q_d.io_en = q_d.io_en & ~`PMX_STRAP_CH;
        end
      end
    end

    if (!resetn) begin
      q_d = rst_state();
    end
  end

  always_ff @(posedge clk) begin
    q_q <= q_d;
  end

  assign avs_readdata            = q_q.rdata;
  assign avs_waitrequest         = q_q.wr;
  assign pad_out                 = q_q.pad_out;
  assign pad_oe_n                = q_q.pad_oe_n;
  assign pull_up_en              = q_q.pu;
  assign pull_dn_en              = q_q.pd;
  assign func_in                 = q_q.pin;
  assign strap_pull_en           = q_q.strap_pu;
  assign addr_ad_enable          = q_q.ad_en;
  assign periph_region7_select_n = q_q.sel7_n;

endmodule

// [dv/pmx_monitor.sv]
module pmx_monitor (
  // clock
  input wire logic              clk,
  input wire logic              resetn,
  // inputs
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic              avs_waitrequest,
  input wire pmx_pkg::pmx_cpu_t cpu,
  input wire logic              all_pins_float_test_mode,
  // outputs
  input wire logic [31:0]       pad_oe_n,
  input wire logic [31:0]       pull_up_en,
  input wire logic [31:0]       pull_dn_en,
  input wire logic              strap_pull_en,
  input wire logic              addr_ad_enable,
  input wire logic              periph_region7_select_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_bus_answer: assert property ((avs_read ^ avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer after one wait cycle");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_pull_excl: assert property ((pull_up_en & pull_dn_en) == 32'h0000_0000)
    else $error("pull up and down together");
  chk_pull_forced: assert property (pull_dn_en[9:7] == 3'h0 && pull_dn_en[5:4] == 2'h0 && !pull_up_en[6])
    else $error("forced pull option broken");
  chk_sel_hold: assert property (cpu.hold |=> periph_region7_select_n)
    else $error("select low in hold");
  chk_sel_phase: assert property (cpu.ale |=> periph_region7_select_n)
    else $error("select low before address phase");
  chk_strap_release: assert property ((cpu.hold || all_pins_float_test_mode) |=> !strap_pull_en)
    else $error("strap pull kept");
  chk_float_pads: assert property (all_pins_float_test_mode |=> (&pad_oe_n) && pull_up_en == 32'h0000_0000)
    else $error("pads not released");
  chk_ad_plain: assert property (!cpu.ul_cycle |=> addr_ad_enable)
    else $error("address phase off outside select cycle");

  cover property (!periph_region7_select_n);
  cover property (!addr_ad_enable);
  cover property (all_pins_float_test_mode);
endmodule

bind pmx_top pmx_monitor u_mon (.clk, .resetn, .avs_read, .avs_write, .avs_waitrequest, .cpu,
  .all_pins_float_test_mode, .pad_oe_n, .pull_up_en, .pull_dn_en, .strap_pull_en, .addr_ad_enable,
  .periph_region7_select_n);

// [dv/pmx_board.sv]
module pmx_board (
  // clock
  input  wire logic        clk,
  // device side
  input  wire logic [31:0] pad_out,
  input  wire logic [31:0] pad_oe_n,
  input  wire logic [31:0] pull_up_en,
  input  wire logic [31:0] pull_dn_en,
  input  wire logic        strap_pull_en,
  // board drive
  input  wire logic [31:0] drv_en,
  input  wire logic [31:0] drv_val,
  input  wire logic        strap_low,
  output logic [31:0]      pad_in,
  output logic             strap
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ph = 1'b0;
  // undriven lines wander so a stale level never passes
  always @(posedge clk) ph <= ~ph;
  assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & drv_en & drv_val)
                | (pad_oe_n & ~drv_en & (pull_up_en | (~pull_dn_en & {32{ph}})));
  assign strap = strap_low ? 1'b0 : (strap_pull_en ? 1'b1 : ph);
endmodule

// [dv/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk, resetn, rd, wr, wreq, fmode, strap, spe, ade, seln, slow;
  logic [3:0]        be;
  logic [4:0]        adr;
  logic [31:0]       wd, rdat, pin, pout, poe, pu, pd, fo, foe, data_bus_enable_out, dval, q, r, d, e, fin;
  logic [19:0]       a;
  pmx_pkg::pmx_cpu_t cpu;
  int                num_errors, checked, cyc;

  pmx_top u_dut (.clk, .resetn, .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wreq), .pad_in(pin), .pad_out(pout),
    .pad_oe_n(poe), .pull_up_en(pu), .pull_dn_en(pd), .func_out(fo), .func_oe_n(foe), .func_in(fin),
    .cpu, .all_pins_float_test_mode(fmode), .addr_bus_enable_strap(strap), .strap_pull_en(spe),
    .addr_ad_enable(ade), .periph_region7_select_n(seln));
  pmx_board u_board (.clk, .pad_out(pout), .pad_oe_n(poe), .pull_up_en(pu), .pull_dn_en(pd),
    .strap_pull_en(spe), .drv_en(data_bus_enable_out), .drv_val(dval), .strap_low(slow), .pad_in(pin), .strap);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      give_verdict();
    end
  end

  task give_verdict;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", nm, x, s);
    end
  endtask
  // forced pull options win over the pull-down register
  function automatic logic [31:0] forced_dn(input logic [31:0] v);
    forced_dn = (v & ~32'h0000_03B0) | 32'h0000_0040;
  endfunction
  // request held until the edge that sees waitrequest low; only the cycle ceiling ends a hang
  task bus(input logic w, input logic [4:0] ad, input logic [31:0] dt);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    be <= 4'hF;
    adr <= ad;
    wd <= dt;
    @(posedge clk);
    while (wreq !== 1'b0) begin
      @(posedge clk);
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    be <= 4'h0;
  endtask
  task settle;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task rst(input logic lo);
    @(posedge clk);
    resetn <= 1'b0;
    slow <= lo;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    slow <= 1'b0;
  endtask
  task post(input logic lo);
    e = lo ? 32'hDBFF_FC0F : 32'hFFFF_FC0F;
    bus(1'b0, 5'h00, 32'h0000_0000);
    chk("io_en", q, e);
    bus(1'b0, 5'h08, 32'h0000_0000);
    chk("pulldn", q, 32'h00C0_0402);
    bus(1'b0, 5'h1C, 32'h0000_0000);
    chk("stat", q, {30'h0000_0000, 1'b1, lo});
    chk("pull_up", pu, e & ~32'h00C0_0402);
    chk("pull_dn", pd, 32'h00C0_0402);
    chk("normal_oe", poe & 32'h0000_03F0, foe & 32'h0000_03F0);
    chk("normal_out", pout & 32'h0000_03F0, fo & 32'h0000_03F0);
    bus(1'b1, 5'h14, 32'h0000_0002);
    cpu.ul_cycle <= 1'b1;
    settle();
    chk("ad_en", 32'(ade), 32'(!lo ? 1'b0 : 1'b1));
    @(posedge clk);
    cpu.ul_cycle <= 1'b0;
  endtask

  initial begin
    {resetn, rd, wr, fmode, slow} = 5'h00;
    {be, adr, wd, data_bus_enable_out, dval} = '0;
    cpu = '0;
    r = $urandom(32'hEDCD_599D);
    fo = $urandom;
    foe = $urandom;
    rst(1'b0);
    post(1'b0);
    bus(1'b1, 5'h00, 32'hFFFF_FFFF);
    r = $urandom;
    bus(1'b1, 5'h08, r);
    e = forced_dn(r);
    settle();
    chk("pd_forced", pd, e);
    chk("pu_forced", pu, ~e);
    r = $urandom;
    bus(1'b1, 5'h04, r);
    d = $urandom;
    bus(1'b1, 5'h0C, d);
    data_bus_enable_out <= 32'hFFFF_FFFF;
    dval <= $urandom;
    repeat (6) @(posedge clk);
    bus(1'b0, 5'h10, 32'h0000_0000);
    e = ~(r & ~d);
    chk("oe_n", poe, e);
    chk("od_high", pout & ~poe, 32'h0000_0000);
    chk("pin", q, dval & e);
    chk("func_in", fin, dval & e);
    data_bus_enable_out <= 32'h0000_0000;
    // channels 2 and 3 back to their address outputs
    bus(1'b1, 5'h00, 32'hFFFF_FFF3);
    r = $urandom;
    bus(1'b1, 5'h18, {23'h00_0000, r[8:0]});
    bus(1'b1, 5'h14, 32'h0000_0000);
    for (int i = 0; i < 17; i++) begin
      if (i == 8) bus(1'b1, 5'h14, 32'h0000_0004);
      a = {r[8:0], (i == 16) ? 3'h6 : 3'(i), 8'($urandom)};
      @(posedge clk);
      cpu <= '{addr: a, ale: 1'b1, cycle: 1'b1, is_io: i[3], ul_cycle: 1'b0, hold: 1'b0};
      @(posedge clk);
      cpu.ale <= 1'b0;
      settle();
      chk("sel", 32'(seln), 32'(!(i < 16 && i % 8 == 6)));
      chk("latched", 32'(pout[3:2]), 32'({a[1], a[2]}));
      @(posedge clk);
      cpu.hold <= 1'b1;
      cpu.ale <= 1'b1;
      cpu.addr <= ~a;
      settle();
      chk("hold_sel", 32'(seln), 32'h0000_0001);
      chk("hold_addr", 32'(pout[3:2]), 32'({a[1], a[2]}));
      @(posedge clk);
      cpu <= '0;
    end
    // ext set: channel 2 shows the region-7 select, channel 3 the region-6 select
    bus(1'b1, 5'h14, 32'h0000_0001);
    a = {r[8:0], 3'h5, 8'($urandom)};
    @(posedge clk);
    cpu <= '{addr: a, ale: 1'b1, cycle: 1'b1, is_io: 1'b0, ul_cycle: 1'b0, hold: 1'b0};
    @(posedge clk);
    cpu.ale <= 1'b0;
    settle();
    chk("ext_pins", 32'(pout[3:2]), 32'h0000_0001);
    chk("ext_sel", 32'(seln), 32'h0000_0001);
    @(posedge clk);
    cpu <= '0;
    fmode <= 1'b1;
    settle();
    chk("float_oe", poe, 32'hFFFF_FFFF);
    chk("strap_pull", 32'(spe), 32'h0000_0000);
    @(posedge clk);
    fmode <= 1'b0;
    rst(1'b1);
    post(1'b1);
    rst(1'b0);
    post(1'b0);
    give_verdict();
  end
endmodule
